// [src/gpp_pin_sync.sv]
// Two-stage synchroniser and edge detector for the asynchronous port pins.
`timescale 1ns/1ns
`default_nettype none

module gpp_pin_sync #(
  parameter int unsigned WIDTH = gpp_pkg::PIN_COUNT
) (
  input  wire logic             clk_sys,    // System clock.
  input  wire logic             rst,        // Asynchronous reset, active high.
  input  wire logic [WIDTH-1:0] pin_async,  // Raw pin levels.
  output logic      [WIDTH-1:0] pin_level,  // Synchronised level.
  output logic      [WIDTH-1:0] pin_rise,   // Rising edge seen this cycle.
  output logic      [WIDTH-1:0] pin_fall    // Falling edge seen this cycle.
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
  } gpp_sync_t;

  gpp_sync_t st_reg;
  gpp_sync_t st_next;

  // The first stage is only ever read by the second stage.
  always_comb
  begin
    st_next      = st_reg;
    st_next.meta = pin_async;
    st_next.sync = st_reg.meta;
    st_next.prev = st_reg.sync;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign pin_level = st_reg.sync;
  assign pin_rise  = st_reg.sync & ~st_reg.prev;
  assign pin_fall  = ~st_reg.sync & st_reg.prev;

endmodule : gpp_pin_sync

`default_nettype wire

// [src/gpp_pkg.sv]
// Shared constants for the general-purpose pin port: address map, field layout, reset values.
package gpp_pkg;

  localparam int unsigned PIN_COUNT     = 12;
  localparam int unsigned BUS_W         = 32;

  // Register byte addresses on the register port.
  localparam logic [31:0] OFF_DIR       = 32'h5000_8000;
  localparam logic [31:0] OFF_SENSE     = 32'h5000_8004;
  localparam logic [31:0] OFF_BOTH      = 32'h5000_8008;
  localparam logic [31:0] OFF_EVENT     = 32'h5000_800C;
  localparam logic [31:0] OFF_MASK      = 32'h5000_8010;
  localparam logic [31:0] OFF_RAW       = 32'h5000_8014;
  localparam logic [31:0] OFF_MASKED    = 32'h5000_8018;
  localparam logic [31:0] OFF_CLEAR     = 32'h5000_801C;

  // Masked data window: address bits from DATA_WIN_LSB upward select it,
  // address bits from DATA_MASK_LSB upward form the per-pin access mask.
  localparam logic [31:0] DATA_BASE     = 32'h5000_0000;
  localparam int unsigned DATA_WIN_LSB  = 14;
  localparam int unsigned DATA_MASK_LSB = 2;

  localparam logic [11:0] RESET_CFG     = 12'h000;
  localparam logic [31:0] READ_IDLE     = 32'h0000_0000;

endpackage : gpp_pkg

// [src/gpp_port.sv]
// General-purpose 12-pin port with direction control and per-pin interrupt detection.
`timescale 1ns/1ns
`default_nettype none

module gpp_port #(
  parameter int unsigned PINS = gpp_pkg::PIN_COUNT
) (
  input  wire logic        clk_sys,            // System clock, 100 MHz.
  input  wire logic        rst,                // Asynchronous reset, active high.
  input  wire logic [31:0] bus_addr,           // Register byte address.
  input  wire logic [31:0] bus_wdata,          // Write data.
  input  wire logic        bus_wr,             // Write strobe, one cycle.
  input  wire logic        bus_rd,             // Read strobe, one cycle.
  output logic      [31:0] bus_rdata,          // Read data, valid the cycle after bus_rd.
  input  wire logic [PINS-1:0] port_pin_in,    // Pin levels from the pads.
  output logic      [PINS-1:0] port_pin_out,   // Output latch driven to the pads.
  output logic      [PINS-1:0] port_pin_oe_n,  // Output enable, low while driving.
  output logic             combined_port_irq   // Port interrupt, level, active high.
);

  // All state except the u_sync synchroniser flops lives in one register, so reset and update stay in one place.
  // Status, interrupt and read data come from st_next and land with their cause.
  typedef struct packed {
    logic [PINS-1:0] dir;
    logic [PINS-1:0] sense;
    logic [PINS-1:0] both;
    logic [PINS-1:0] evt;
    logic [PINS-1:0] mask;
    logic [PINS-1:0] data;
    logic [PINS-1:0] edge_lat;
    logic [PINS-1:0] ris;
    logic [PINS-1:0] oe_n;
    logic            irq;
    logic [31:0]     rdata;
  } gpp_state_t;

  gpp_state_t st_reg;
  gpp_state_t st_next;

  logic [PINS-1:0] pin_level;
  logic [PINS-1:0] pin_rise;
  logic [PINS-1:0] pin_fall;
  logic [PINS-1:0] edge_hit;
  logic [PINS-1:0] lvl_hit;
  logic [PINS-1:0] clr_vec;
  logic [PINS-1:0] acc_mask;
  logic [PINS-1:0] wdata_pins;

  function automatic logic sel(input logic [31:0] a, input logic [31:0] off);
    return a == off;
  endfunction : sel

  // The data window sits below the register block; address bits 13:2 act as a pin mask.
  function automatic logic in_data_win(input logic [31:0] a);
    return (a >> gpp_pkg::DATA_WIN_LSB) == (gpp_pkg::DATA_BASE >> gpp_pkg::DATA_WIN_LSB);
  endfunction : in_data_win

  // Pads are asynchronous to clk_sys, so nothing reads them before two flops.
  gpp_pin_sync #(
    .WIDTH     (PINS)
  ) u_sync (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .pin_async (port_pin_in),
    .pin_level (pin_level),
    .pin_rise  (pin_rise),
    .pin_fall  (pin_fall)
  );

  assign wdata_pins = bus_wdata[PINS-1:0];
  assign acc_mask   = bus_addr[gpp_pkg::DATA_MASK_LSB +: PINS];

  // Trigger qualification works on the configuration in force this cycle.
  always_comb
  begin
    edge_hit = ~st_reg.sense & ((st_reg.both & (pin_rise | pin_fall))
             | (~st_reg.both & st_reg.evt & pin_rise)
             | (~st_reg.both & ~st_reg.evt & pin_fall));
    lvl_hit  = st_reg.sense & ~(pin_level ^ st_reg.evt);
    clr_vec  = (bus_wr && sel(bus_addr, gpp_pkg::OFF_CLEAR)) ? wdata_pins : '0;
  end

  always_comb
  begin
    st_next = st_reg;
    // Only the low PINS bits of write data are stored; the rest is dropped.
    if (bus_wr)
    begin
      if (sel(bus_addr, gpp_pkg::OFF_DIR))
        st_next.dir = wdata_pins;
      if (sel(bus_addr, gpp_pkg::OFF_SENSE))
        st_next.sense = wdata_pins;
      if (sel(bus_addr, gpp_pkg::OFF_BOTH))
        st_next.both = wdata_pins;
      if (sel(bus_addr, gpp_pkg::OFF_EVENT))
        st_next.evt = wdata_pins;
      if (sel(bus_addr, gpp_pkg::OFF_MASK))
        st_next.mask = wdata_pins;
      if (in_data_win(bus_addr))
        st_next.data = (st_reg.data & ~acc_mask) | (wdata_pins & acc_mask);
    end
    // Edge pins trigger whatever their direction, because the pad level is read back.
    // A new edge in the clearing cycle wins, so no event is lost.
    // Level pins never see their latch touched by a clear write.
    st_next.edge_lat = (st_reg.edge_lat & ~(clr_vec & ~st_reg.sense)) | edge_hit;
    st_next.ris  = (st_reg.sense & lvl_hit) | (~st_reg.sense & st_next.edge_lat);
    st_next.oe_n = ~st_next.dir;
    st_next.irq  = |(st_next.ris & st_next.mask);
    // Read data stand one cycle only; the clear register and holes read as zero.
    st_next.rdata = gpp_pkg::READ_IDLE;
    if (bus_rd)
    begin
      if (sel(bus_addr, gpp_pkg::OFF_DIR))
        st_next.rdata = 32'(st_reg.dir);
      else if (sel(bus_addr, gpp_pkg::OFF_SENSE))
        st_next.rdata = 32'(st_reg.sense);
      else if (sel(bus_addr, gpp_pkg::OFF_BOTH))
        st_next.rdata = 32'(st_reg.both);
      else if (sel(bus_addr, gpp_pkg::OFF_EVENT))
        st_next.rdata = 32'(st_reg.evt);
      else if (sel(bus_addr, gpp_pkg::OFF_MASK))
        st_next.rdata = 32'(st_reg.mask);
      else if (sel(bus_addr, gpp_pkg::OFF_RAW))
        st_next.rdata = 32'(st_reg.ris);
      else if (sel(bus_addr, gpp_pkg::OFF_MASKED))
        st_next.rdata = 32'(st_reg.ris & st_reg.mask);
      else if (in_data_win(bus_addr))
        st_next.rdata = 32'(pin_level & acc_mask);
    end
  end

  // Pins come out of reset as inputs with all interrupts masked.
  // The reset branch assigns constants only, so it stays a plain asynchronous reset.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_reg          <= '0;
      st_reg.dir      <= gpp_pkg::RESET_CFG[PINS-1:0];
      st_reg.sense    <= gpp_pkg::RESET_CFG[PINS-1:0];
      st_reg.both     <= gpp_pkg::RESET_CFG[PINS-1:0];
      st_reg.evt      <= gpp_pkg::RESET_CFG[PINS-1:0];
      st_reg.mask     <= gpp_pkg::RESET_CFG[PINS-1:0];
      st_reg.oe_n     <= '1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Every output is a register field, so pads and the interrupt line never glitch.
  assign bus_rdata         = st_reg.rdata;
  assign port_pin_out      = st_reg.data;
  assign port_pin_oe_n     = st_reg.oe_n;
  assign combined_port_irq = st_reg.irq;

  // Helper views for the checks below.
  logic [PINS-1:0] cfg_sense;
  logic [PINS-1:0] ris_q;
  logic [PINS-1:0] mis_q;
  logic [PINS-1:0] lat_q;
  logic [PINS-1:0] both_ev;
  logic [PINS-1:0] fall_ev;
  logic [PINS-1:0] clr_edge;
  logic [PINS-1:0] lvl_pins;

  // Pins that see an edge and a clear bit in one cycle; the edge must survive.
  logic [PINS-1:0] rise_ev;
  logic [PINS-1:0] race_pins;
  logic            data_wr;
  logic            data_rd;

  assign cfg_sense = st_reg.sense;
  assign ris_q     = st_reg.ris;
  assign mis_q     = st_reg.ris & st_reg.mask;
  assign lat_q     = st_reg.edge_lat;
  assign both_ev   = ~st_reg.sense & st_reg.both & (pin_rise | pin_fall);
  assign fall_ev   = ~st_reg.sense & ~st_reg.both & ~st_reg.evt & pin_fall;
  assign clr_edge  = clr_vec & ~st_reg.sense;
  assign lvl_pins  = st_reg.sense & lvl_hit;

  assign rise_ev   = ~st_reg.sense & ~st_reg.both & st_reg.evt & pin_rise;
  assign race_pins = clr_edge & edge_hit;
  assign data_wr   = bus_wr & in_data_win(bus_addr);
  assign data_rd   = bus_rd & in_data_win(bus_addr);

  // All checks share clk_sys and are switched off while reset is high.
  // Most compare a registered result with the inputs one edge earlier,
  // because every status bit is computed from st_next and lands one edge later.
  // A check that used st_reg alone would miss a wrong next-state equation.

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  dir_write_a: assert property (
    bus_wr && sel(bus_addr, gpp_pkg::OFF_DIR) |=> port_pin_oe_n == ~$past(wdata_pins))
    else $error("Output enable does not follow direction write.");

  level_track_a: assert property (
    1'b1 |=> ((ris_q ^ $past(lvl_hit)) & $past(cfg_sense)) == '0)
    else $error("Level pin raw status does not follow its level.");

  both_edge_a: assert property (
    1'b1 |=> (ris_q & $past(both_ev)) == $past(both_ev))
    else $error("Both-edge event did not set raw status.");

  fall_sel_a: assert property (
    |fall_ev |=> (ris_q & $past(fall_ev)) == $past(fall_ev))
    else $error("Falling edge did not set raw status.");

  mask_block_a: assert property (
    st_reg.mask == '0 |-> !combined_port_irq)
    else $error("Interrupt raised with all pins masked.");

  raw_read_a: assert property (
    bus_rd && sel(bus_addr, gpp_pkg::OFF_RAW) |=> bus_rdata == 32'($past(ris_q)))
    else $error("Raw status read returned wrong value.");

  masked_read_a: assert property (
    bus_rd && sel(bus_addr, gpp_pkg::OFF_MASKED) |=> bus_rdata == 32'($past(mis_q)))
    else $error("Masked status read returned wrong value.");

  edge_clear_a: assert property (
    |clr_edge |=> (ris_q & $past(clr_edge) & ~$past(edge_hit)) == '0)
    else $error("Edge latch not cleared by clear write.");

  level_ignore_a: assert property (
    |clr_vec |=> ((lat_q ^ $past(lat_q)) & $past(cfg_sense)) == '0)
    else $error("Clear write changed a level pin latch.");

  port_irq_a: assert property (
    combined_port_irq == |mis_q)
    else $error("Port interrupt disagrees with masked status.");

  reserved_zero_a: assert property (
    (bus_rdata >> PINS) == '0)
    else $error("Reserved read data bits are not zero.");

  read_once_a: assert property (
    !bus_rd |=> bus_rdata == gpp_pkg::READ_IDLE)
    else $error("Read data present without a read strobe.");

  rise_sel_a: assert property (
    |rise_ev |=> (ris_q & $past(rise_ev)) == $past(rise_ev))
    else $error("Rising edge did not set raw status.");

  set_wins_a: assert property (
    |race_pins |=> (lat_q & $past(race_pins)) == $past(race_pins))
    else $error("Edge arriving with a clear write was lost.");

  latch_hold_a: assert property (
    1'b1 |=> ((lat_q ^ $past(lat_q)) & ~$past(edge_hit) & ~$past(clr_edge)) == '0)
    else $error("Edge latch changed without an edge or a clear bit.");

  dir_reflect_a: assert property (
    port_pin_oe_n == ~st_reg.dir)
    else $error("Output enable disagrees with the direction register.");

  mask_write_a: assert property (
    bus_wr && sel(bus_addr, gpp_pkg::OFF_MASK) |=>
      combined_port_irq == |(ris_q & $past(wdata_pins)))
    else $error("Port interrupt does not follow a mask write.");

  clr_read_zero_a: assert property (
    bus_rd && sel(bus_addr, gpp_pkg::OFF_CLEAR) |=> bus_rdata == gpp_pkg::READ_IDLE)
    else $error("Write-only clear register returned data.");

  // The output latch is touched only by a data window write.
  data_write_a: assert property (
    data_wr |=> port_pin_out == (($past(port_pin_out) & ~$past(acc_mask))
                               | ($past(wdata_pins) & $past(acc_mask))))
    else $error("Masked data write did not update the output latch.");

  data_hold_a: assert property (
    !data_wr |=> $stable(port_pin_out))
    else $error("Output latch changed without a data write.");

  data_read_a: assert property (
    data_rd |=> bus_rdata == 32'($past(pin_level & acc_mask)))
    else $error("Data window read returned wrong pin levels.");

  // Covers mark the scenarios that the bench is meant to reach.

  clear_seen_c: cover property (|clr_edge ##1 combined_port_irq == 1'b0);
  irq_rise_c:   cover property ($rose(combined_port_irq));
  level_irq_c:  cover property (|(lvl_pins & st_reg.mask) ##1 combined_port_irq);
  both_edge_c:  cover property (|both_ev ##1 |ris_q);
  race_c:       cover property (|race_pins ##1 |ris_q);

endmodule : gpp_port

`default_nettype wire

// [test/gpp_pin_model.sv]
// Pad model for the port pins: outside drivers resolved against the port's own output buffers.
`timescale 1ns/1ns
`default_nettype none

module gpp_pin_model (
  input  wire logic [11:0] ext_level,      // Level applied by the outside world.
  input  wire logic [11:0] port_pin_out,   // Output latch of the port.
  input  wire logic [11:0] port_pin_oe_n,  // Port output enable, active low.
  output logic      [11:0] port_pin_in     // Resolved pad level back to the port.
);
  // A driven pad shows the latch, so the outside driver must give way to it.
  assign port_pin_in = (port_pin_oe_n & ext_level) | (~port_pin_oe_n & port_pin_out);
endmodule : gpp_pin_model
`default_nettype wire

// [test/gpp_port_tb.sv]
// Self-checking bench for the pin port: registers, direction and pin interrupts.
`timescale 1ns/1ns
`default_nettype none

module gpp_port_tb;
  logic        clk_sys;
  logic        rst;
  logic [31:0] bus_addr;
  logic [31:0] bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [31:0] bus_rdata;
  logic [11:0] ext_level;
  logic [11:0] port_pin_in;
  logic [11:0] port_pin_out;
  logic [11:0] port_pin_oe_n;
  logic        combined_port_irq;
  int          error_cnt;
  int          comparisons;
  int          cycles = 0;

  gpp_port #(.PINS(12)) i_gpp_port (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
    .port_pin_oe_n(port_pin_oe_n), .combined_port_irq(combined_port_irq));

  gpp_pin_model i_gpp_pin_model (.ext_level(ext_level), .port_pin_out(port_pin_out),
    .port_pin_oe_n(port_pin_oe_n), .port_pin_in(port_pin_in));

  always #5 clk_sys = ~clk_sys;

  task automatic finish_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // The whole sequence needs well under a thousand cycles; a hang is cut off here.
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      error_cnt = error_cnt + 1;
      finish_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [31:0] addr, input logic [31:0] data);
    @(posedge clk_sys);
    bus_wr    <= 1'b1;
    bus_addr  <= addr;
    bus_wdata <= data;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are sampled just then.
  task automatic rd(input string name, input logic [31:0] addr, input logic [31:0] exp);
    @(posedge clk_sys);
    bus_rd   <= 1'b1;
    bus_addr <= addr;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1;
    chk(name, exp, bus_rdata);
  endtask : rd

  // Two sync flops and the detector take three edges; four leaves margin.
  task automatic pins(input logic [11:0] lvl);
    @(posedge clk_sys);
    ext_level <= lvl;
    repeat (4) @(posedge clk_sys);
  endtask : pins

  task automatic chk_irq(input logic exp);
    #1;
    chk("irq", {31'h0, exp}, {31'h0, combined_port_irq});
  endtask : chk_irq

  task automatic t_reset;
    rd("direction", gpp_pkg::OFF_DIR, 32'h0);
    rd("sense", gpp_pkg::OFF_SENSE, 32'h0);
    rd("both", gpp_pkg::OFF_BOTH, 32'h0);
    rd("event", gpp_pkg::OFF_EVENT, 32'h0);
    rd("mask", gpp_pkg::OFF_MASK, 32'h0);
    rd("raw", gpp_pkg::OFF_RAW, 32'h0);
    rd("masked", gpp_pkg::OFF_MASKED, 32'h0);
    chk("oe_n", 32'h0000_0FFF, {20'h0, port_pin_oe_n});
    chk_irq(1'b0);
  endtask : t_reset

  task automatic t_regs;
    logic [31:0] regs [5];
    regs = '{gpp_pkg::OFF_DIR, gpp_pkg::OFF_SENSE, gpp_pkg::OFF_BOTH, gpp_pkg::OFF_EVENT,
             gpp_pkg::OFF_MASK};
    for (int i = 0; i < 5; i++)
    begin
      wr(regs[i], 32'hFFFF_FFFF);
      rd("config", regs[i], 32'h0000_0FFF);
      wr(regs[i], 32'h0);
    end
    wr(gpp_pkg::OFF_RAW, 32'h0000_0FFF);
    rd("raw", gpp_pkg::OFF_RAW, 32'h0);
    rd("clear", gpp_pkg::OFF_CLEAR, 32'h0);
    rd("unmapped", 32'h5000_8020, 32'h0);
  endtask : t_regs

  task automatic t_direction;
    wr(gpp_pkg::OFF_DIR, 32'h0000_0005);
    #1;
    chk("oe_n", 32'h0000_0FFA, {20'h0, port_pin_oe_n});
    wr(gpp_pkg::OFF_DIR, 32'h0);
    #1;
    chk("oe_n", 32'h0000_0FFF, {20'h0, port_pin_oe_n});
  endtask : t_direction

  task automatic t_fall_edge;
    pins(12'h021);
    wr(gpp_pkg::OFF_CLEAR, 32'h0000_0FFF);
    wr(gpp_pkg::OFF_MASK, 32'h0000_0001);
    rd("raw", gpp_pkg::OFF_RAW, 32'h0);
    pins(12'h000);
    chk_irq(1'b1);
    rd("raw", gpp_pkg::OFF_RAW, 32'h0000_0021);
    rd("masked", gpp_pkg::OFF_MASKED, 32'h0000_0001);
    wr(gpp_pkg::OFF_CLEAR, 32'h0000_0002);
    rd("raw", gpp_pkg::OFF_RAW, 32'h0000_0021);
    wr(gpp_pkg::OFF_CLEAR, 32'h0000_0001);
    chk_irq(1'b0);
    rd("raw", gpp_pkg::OFF_RAW, 32'h0000_0020);
    wr(gpp_pkg::OFF_MASK, 32'h0000_0020);
    chk_irq(1'b1);
    wr(gpp_pkg::OFF_MASK, 32'h0);
    wr(gpp_pkg::OFF_CLEAR, 32'h0000_0FFF);
  endtask : t_fall_edge

  task automatic t_rise_both;
    wr(gpp_pkg::OFF_EVENT, 32'h0000_0002);
    wr(gpp_pkg::OFF_BOTH, 32'h0000_0004);
    pins(12'h006);
    rd("raw", gpp_pkg::OFF_RAW, 32'h0000_0006);
    wr(gpp_pkg::OFF_CLEAR, 32'h0000_0006);
    pins(12'h000);
    rd("raw", gpp_pkg::OFF_RAW, 32'h0000_0004);
    wr(gpp_pkg::OFF_EVENT, 32'h0);
    wr(gpp_pkg::OFF_BOTH, 32'h0);
    wr(gpp_pkg::OFF_CLEAR, 32'h0000_0FFF);
  endtask : t_rise_both

  task automatic t_level;
    wr(gpp_pkg::OFF_SENSE, 32'h0000_0008);
    wr(gpp_pkg::OFF_EVENT, 32'h0000_0008);
    wr(gpp_pkg::OFF_MASK, 32'h0000_0008);
    pins(12'h008);
    chk_irq(1'b1);
    wr(gpp_pkg::OFF_CLEAR, 32'h0000_0008);
    rd("raw", gpp_pkg::OFF_RAW, 32'h0000_0008);
    pins(12'h000);
    chk_irq(1'b0);
    wr(gpp_pkg::OFF_EVENT, 32'h0);
    repeat (2) @(posedge clk_sys);
    rd("masked", gpp_pkg::OFF_MASKED, 32'h0000_0008);
    wr(gpp_pkg::OFF_MASK, 32'h0);
    chk_irq(1'b0);
    rd("raw", gpp_pkg::OFF_RAW, 32'h0000_0008);
    wr(gpp_pkg::OFF_SENSE, 32'h0);
  endtask : t_level

  // The clear write is sampled at the very edge that latches the falling pin.
  task automatic t_clear_race;
    pins(12'h010);
    @(posedge clk_sys);
    ext_level <= 12'h000;
    @(posedge clk_sys);
    wr(gpp_pkg::OFF_CLEAR, 32'h0000_0010);
    rd("raw", gpp_pkg::OFF_RAW, 32'h0000_0010);
    wr(gpp_pkg::OFF_CLEAR, 32'h0000_0010);
    rd("raw", gpp_pkg::OFF_RAW, 32'h0);
  endtask : t_clear_race

  // Address bits 13:2 mask a data window access pin by pin.
  task automatic t_data;
    wr(gpp_pkg::DATA_BASE + 32'h0000_3FFC, 32'h0000_0A5A);
    #1;
    chk("pin_out", 32'h0000_0A5A, {20'h0, port_pin_out});
    wr(gpp_pkg::DATA_BASE + 32'h0000_003C, 32'h0000_0FF5);
    #1;
    chk("pin_out", 32'h0000_0A55, {20'h0, port_pin_out});
    pins(12'h0C3);
    rd("data", gpp_pkg::DATA_BASE + 32'h0000_3FFC, 32'h0000_00C3);
    rd("data", gpp_pkg::DATA_BASE + 32'h0000_0300, 32'h0000_00C0);
    wr(gpp_pkg::OFF_DIR, 32'h0000_0FFF);
    repeat (3) @(posedge clk_sys);
    rd("data", gpp_pkg::DATA_BASE + 32'h0000_3FFC, 32'h0000_0A55);
    rd("raw", gpp_pkg::OFF_RAW, 32'h0000_0082);
  endtask : t_data

  // A reset in mid-run must bring back every reset value, whatever was set.
  task automatic t_mid_reset;
    wr(gpp_pkg::OFF_MASK, 32'h0000_0FFF);
    chk_irq(1'b1);
    @(posedge clk_sys);
    rst       <= 1'b1;
    ext_level <= 12'h000;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_reset();
    chk("pin_out", 32'h0, {20'h0, port_pin_out});
  endtask : t_mid_reset

  initial
  begin
    clk_sys     = 1'b0;
    rst         = 1'b1;
    bus_addr    = 32'h0;
    bus_wdata   = 32'h0;
    bus_wr      = 1'b0;
    bus_rd      = 1'b0;
    ext_level   = 12'h000;
    error_cnt   = 0;
    comparisons = 0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_regs();
    t_direction();
    t_fall_edge();
    t_rise_both();
    t_level();
    t_clear_race();
    t_data();
    t_mid_reset();
    finish_test();
  end
endmodule : gpp_port_tb
`default_nettype wire
